// ---- hw/sld_pkg.sv ----
/*
  Package for the status indicator driver: slave state codes, flash timing
  constants and safe output value.
  Assumes a 200 MHz system clock.
*/
package sld_pkg;

  // Slave state machine states as reported by the communication core.
  typedef enum logic [2:0]
  {
    SLD_ST_INIT,
    SLD_ST_PREOP,
    SLD_ST_BOOT,
    SLD_ST_SAFEOP,
    SLD_ST_OP
  } sld_state_t;

  // Raw state codes on the state input.
  localparam logic [2:0] SLD_CODE_INIT = 3'h1;
  localparam logic [2:0] SLD_CODE_PREOP = 3'h2;
  localparam logic [2:0] SLD_CODE_BOOT = 3'h3;
  localparam logic [2:0] SLD_CODE_SAFEOP = 3'h4;
  localparam logic [2:0] SLD_CODE_OP = 3'h5;

  // Clock rate and flash timing.
  localparam int SLD_CLK_MHZ = 200;
  localparam int SLD_FLASH_HALF_MS = 200;
  localparam int SLD_SINGLE_ON_MS = 200;
  localparam int SLD_SINGLE_OFF_MS = 1000;
  localparam int SLD_FLASH_HALF_CYC = SLD_FLASH_HALF_MS * 1000 * SLD_CLK_MHZ;
  localparam int SLD_SINGLE_ON_CYC = SLD_SINGLE_ON_MS * 1000 * SLD_CLK_MHZ;
  localparam int SLD_SINGLE_OFF_CYC = SLD_SINGLE_OFF_MS * 1000 * SLD_CLK_MHZ;

  // Width of the timing counter.
  localparam int SLD_CNT_W = 28;

  // Process output width and its safe value.
  localparam int SLD_OUT_W = 8;
  localparam logic [7:0] SLD_SAFE_OUT = 8'h00;

endpackage

// ---- hw/sld_sync.sv ----
/*
  Two flip-flop synchroniser for a group of asynchronous input levels.
  Assumes inputs are quasi-static levels from pins.
*/
`timescale 1ns/1ps
module sld_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Levels in and out.
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // Two stages; the first is read only by the second.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// ---- hw/sld_status_led.sv ----
/*
  Front-panel status indicator driver for an incremental encoder terminal:
  latch, gate and alarm level indicators, alarm error bit, and a run
  indicator whose pattern shows the slave state, plus safe-state gating of
  process outputs.
  Assumes field inputs are already level shifted to logic levels; the alarm
  pin's pull-up sits in the input stage, so an open input reads high.
*/
// Operation
// - Red alarm indicator lit while alarm input is low, else dark.
// - Alarm input idles high; unconnected input gives no alarm.
// - Green latch indicator follows the latch input level.
// - Green gate indicator follows the gate input level.
// - Run indicator off in INIT or BOOT-STRAP.
// - Run indicator flashes continuously in PREOP.
// - Run indicator shows repeating single flash in SAFEOP.
// - In SAFEOP process outputs are held at their safe value.
// - Run indicator steadily lit in OP.
// - Alarm input low also sets an error status bit.
`timescale 1ns/1ps
module sld_status_led
  import sld_pkg::*;
#(
  parameter int FLASH_HALF_CYC = SLD_FLASH_HALF_CYC,
  parameter int SINGLE_ON_CYC = SLD_SINGLE_ON_CYC,
  parameter int SINGLE_OFF_CYC = SLD_SINGLE_OFF_CYC
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Field inputs from pins.
  input wire logic i_latch,
  input wire logic i_gate,
  input wire logic i_alarm_n,
  // Slave state and process data from the communication core.
  input wire logic [2:0] i_slave_state,
  input wire logic [SLD_OUT_W-1:0] i_proc_out,
  // Indicators.
  output logic o_led_latch,
  output logic o_led_gate,
  output logic o_led_alarm,
  output logic o_led_run,
  // Status and process outputs.
  output logic o_alarm_err,
  output logic [SLD_OUT_W-1:0] o_proc_out
);

  logic [2:0] pins_s;
  sld_state_t st;
  logic [SLD_CNT_W-1:0] cnt_q, cnt_d;
  logic ph_q, ph_d;
  logic run_q, run_d;
  logic latch_q, latch_d, gate_q, gate_d, alarm_q, alarm_d, err_q, err_d;
  logic [SLD_OUT_W-1:0] pout_q, pout_d;

  // Alarm resets to high so no false alarm shows while synchronising.
  sld_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async({i_alarm_n, i_gate, i_latch}),
    .o_sync(pins_s)
  );

  // Decode the raw state code; code 0 counts as INIT, codes 6 and 7 count as OP.
  always_comb
  begin
    unique case (i_slave_state)
      SLD_CODE_PREOP: st = SLD_ST_PREOP;
      SLD_CODE_BOOT: st = SLD_ST_BOOT;
      SLD_CODE_SAFEOP: st = SLD_ST_SAFEOP;
      SLD_CODE_OP, 3'h6, 3'h7: st = SLD_ST_OP;
      default: st = SLD_ST_INIT;
    endcase
  end

  // Level indicators, error bit and process output gating.
  always_comb
  begin
    latch_d = pins_s[0];
    gate_d = pins_s[1];
    alarm_d = ~pins_s[2];
    err_d = ~pins_s[2];
    pout_d = (st == SLD_ST_OP) ? i_proc_out : SLD_SAFE_OUT;
  end

  // Run pattern timing: counter and phase.
  always_comb
  begin
    cnt_d = cnt_q + 1'b1;
    ph_d = ph_q;
    run_d = 1'b0;
    unique case (st)
      SLD_ST_INIT, SLD_ST_BOOT:
      begin
        cnt_d = '0;
        ph_d = 1'b0;
      end
      SLD_ST_PREOP:
      begin
        if (cnt_q >= SLD_CNT_W'(FLASH_HALF_CYC - 1))
        begin
          cnt_d = '0;
          ph_d = ~ph_q;
        end
        run_d = ph_d;
      end
      SLD_ST_SAFEOP:
      begin
        if (!ph_q && cnt_q >= SLD_CNT_W'(SINGLE_ON_CYC - 1))
        begin
          cnt_d = '0;
          ph_d = 1'b1;
        end
        else if (ph_q && cnt_q >= SLD_CNT_W'(SINGLE_OFF_CYC - 1))
        begin
          cnt_d = '0;
          ph_d = 1'b0;
        end
        run_d = ~ph_d;
      end
      SLD_ST_OP:
      begin
        cnt_d = '0;
        ph_d = 1'b0;
        run_d = 1'b1;
      end
    endcase
  end

  // Register all state and outputs.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q <= '0;
      ph_q <= 1'b0;
      run_q <= 1'b0;
      latch_q <= 1'b0;
      gate_q <= 1'b0;
      alarm_q <= 1'b0;
      err_q <= 1'b0;
      pout_q <= SLD_SAFE_OUT;
    end
    else
    begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      run_q <= run_d;
      latch_q <= latch_d;
      gate_q <= gate_d;
      alarm_q <= alarm_d;
      err_q <= err_d;
      pout_q <= pout_d;
    end
  end

  assign o_led_latch = latch_q;
  assign o_led_gate = gate_q;
  assign o_led_alarm = alarm_q;
  assign o_alarm_err = err_q;
  assign o_led_run = run_q;
  assign o_proc_out = pout_q;

  // Checks.
  property p_alarm;
    @(posedge i_clk) disable iff (!i_nrst) $fell(pins_s[2]) |=> o_led_alarm && o_alarm_err;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm indicator not lit");

  property p_idle;
    @(posedge i_clk) disable iff (!i_nrst) pins_s[2] |=> !o_led_alarm && !o_alarm_err;
  endproperty
  a_idle: assert property (p_idle) else $error("alarm shown while input high");

  property p_latch;
    @(posedge i_clk) disable iff (!i_nrst) 1'b1 |=> o_led_latch == $past(pins_s[0]);
  endproperty
  a_latch: assert property (p_latch) else $error("latch indicator wrong");

  property p_gate;
    @(posedge i_clk) disable iff (!i_nrst) 1'b1 |=> o_led_gate == $past(pins_s[1]);
  endproperty
  a_gate: assert property (p_gate) else $error("gate indicator wrong");

  property p_off;
    @(posedge i_clk) disable iff (!i_nrst) (st == SLD_ST_INIT || st == SLD_ST_BOOT) |=> !o_led_run;
  endproperty
  a_off: assert property (p_off) else $error("run lit in init");

  property p_on;
    @(posedge i_clk) disable iff (!i_nrst) (i_nrst && st == SLD_ST_OP) [*2] |-> o_led_run;
  endproperty
  a_on: assert property (p_on) else $error("run dark in op");

  property p_safe;
    @(posedge i_clk) disable iff (!i_nrst) (st == SLD_ST_SAFEOP) |=> o_proc_out == SLD_SAFE_OUT;
  endproperty
  a_safe: assert property (p_safe) else $error("outputs not safe");

  property p_flash;
    @(posedge i_clk) disable iff (!i_nrst)
      (st == SLD_ST_PREOP && cnt_q == '0 && $changed(ph_q)) |-> ##1 (o_led_run == ph_q);
  endproperty
  a_flash: assert property (p_flash) else $error("flash phase not shown");

  // The flash counter never runs past one half period once in PREOP.
  property p_flash_cnt;
    @(posedge i_clk) disable iff (!i_nrst)
      (st == SLD_ST_PREOP) |=> (st != SLD_ST_PREOP) || (cnt_q < SLD_CNT_W'(FLASH_HALF_CYC));
  endproperty
  a_flash_cnt: assert property (p_flash_cnt) else $error("flash counter overran half period");

  property p_single;
    @(posedge i_clk) disable iff (!i_nrst) (st == SLD_ST_SAFEOP && ph_q) |=> (st != SLD_ST_SAFEOP) || !o_led_run || !ph_q;
  endproperty
  a_single: assert property (p_single) else $error("single flash lit in gap");

endmodule

// ---- tb/sld_field_model.sv ----
/*
  Field side model: the latch and gate 24 V sources and the encoder alarm contact.
  Assumes the bench sets the levels, and that the alarm line has a pull-up, so an open contact reads high.
*/
`timescale 1ns/1ps
module sld_field_model
(
  // Field conditions set by the bench.
  input wire logic i_latch_on,
  input wire logic i_gate_on,
  input wire logic i_alarm_gnd,
  // Pin levels seen by the terminal.
  output logic o_latch,
  output logic o_gate,
  output logic o_alarm_n
);
  assign o_latch = i_latch_on;
  assign o_gate = i_gate_on;
  assign o_alarm_n = i_alarm_gnd ? 1'b0 : 1'b1;
endmodule

// ---- tb/test_status_led_driver.sv ----
/*
  Self-checking bench for the status indicator driver, with short flash counts.
  Assumes the field model above, three edges from pin to indicator and one
  edge from slave state or process data to the outputs.
*/
`timescale 1ns/1ps
module test_status_led_driver;
  import sld_pkg::*;
  typedef struct {int due; int kind; logic [7:0] exp;} sld_note_t;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic lat = 1'b0, gat = 1'b0, alm = 1'b0;
  logic i_latch, i_gate, i_alarm_n;
  logic [2:0] i_slave_state = 3'h1;
  logic [7:0] i_proc_out = 8'h00;
  logic [7:0] lfsr = 8'h0c;
  logic [7:0] got;
  logic o_led_latch, o_led_gate, o_led_alarm, o_led_run, o_alarm_err;
  logic [7:0] o_proc_out;
  int cyc = 0, n_mismatch = 0, n_tests = 0, run_cnt = 0;
  sld_note_t q[$];
  sld_note_t nt;

  sld_field_model sld_field_model_i (.i_latch_on(lat), .i_gate_on(gat), .i_alarm_gnd(alm),
    .o_latch(i_latch), .o_gate(i_gate), .o_alarm_n(i_alarm_n));

  sld_status_led #(.FLASH_HALF_CYC(8), .SINGLE_ON_CYC(4), .SINGLE_OFF_CYC(12)) sld_status_led_i (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_latch(i_latch), .i_gate(i_gate), .i_alarm_n(i_alarm_n),
    .i_slave_state(i_slave_state), .i_proc_out(i_proc_out), .o_led_latch(o_led_latch),
    .o_led_gate(o_led_gate), .o_led_alarm(o_led_alarm), .o_led_run(o_led_run),
    .o_alarm_err(o_alarm_err), .o_proc_out(o_proc_out));

  // Clock of 5 ns period.
  always #2.5 i_clk = ~i_clk;

  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cycle count and a ceiling that cuts a hang short.
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch++;
      final_report;
    end
  end

  // Notes an expected result, due a number of cycles after this edge.
  task note(input int d, input int k, input logic [7:0] e);
    q.push_back('{cyc + d, k, e});
  endtask

  // Monitor: counts lit run cycles, compares each due note of kind 0 to 2, and clears the count on a kind 3 note.
  always @(negedge i_clk)
  begin
    run_cnt = run_cnt + ((o_led_run === 1'b1) ? 1 : 0);
    while (q.size() > 0 && q[0].due <= cyc)
    begin
      nt = q.pop_front();
      got = (nt.kind == 0) ? {4'h0, o_led_latch, o_led_gate, o_led_alarm, o_alarm_err} :
            (nt.kind == 1) ? o_proc_out : 8'(run_cnt);
      if (nt.kind == 3)
        run_cnt = 0;
      else
      begin
        n_tests++;
        if (got !== nt.exp)
        begin
          n_mismatch++;
          $display("[ERR] t=%0t exp=%h got=%h", $time, nt.exp, got);
        end
      end
    end
  end

  // Sets the field levels; indicators follow three edges later.
  task pins(input logic l, input logic g, input logic a);
    @(posedge i_clk);
    lat <= l;
    gat <= g;
    alm <= a;
    note(4, 0, {4'h0, l, g, a, a});
    repeat (4) @(posedge i_clk);
  endtask

  // Sets a slave state with fresh process data, then counts lit cycles over 64.
  task st(input logic [2:0] c, input logic [7:0] ex);
    @(posedge i_clk);
    i_slave_state <= c;
    lfsr = nxt(lfsr);
    i_proc_out <= lfsr;
    note(2, 1, (c >= 3'h5) ? lfsr : 8'h00);
    note(34, 3, 8'h00);
    note(98, 2, ex);
    repeat (100) @(posedge i_clk);
    $display("state %0d test done", c);
  endtask

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 8; i++)
      pins(i[2], i[1], i[0]);
    // Reset in mid-run with every input active: outputs clear, no false alarm on release.
    @(posedge i_clk);
    i_nrst <= 1'b0;
    note(1, 0, 8'h00);
    note(1, 1, 8'h00);
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    note(2, 0, 8'h00);
    note(4, 0, 8'h0f);
    repeat (4) @(posedge i_clk);
    $display("reset test done");
    pins(1'b0, 1'b0, 1'b0);
    $display("field input test done");
    st(3'h1, 8'd0);
    st(3'h2, 8'd32);
    st(3'h3, 8'd0);
    st(3'h4, 8'd16);
    st(3'h5, 8'd64);
    st(3'h0, 8'd0);
    st(3'h7, 8'd64);
    st(3'h6, 8'd64);
    st(3'h4, 8'd16);
    final_report;
  end
endmodule
